// ---- src/efcs_device.sv ----
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Operation
// - Busy flag high at power-up and operations
// - Busy ignores all but status and ID
// - Operation end clears the busy flag
// - Threshold lives in bits 7:4 at 10h
// - Host writes threshold only one to seven
// - Threshold resets to four flips
// - Page read with ECC updates flags at 20h
// - Flag set when count reaches threshold
// - Four sector counts readable at 40h, 50h
// - Sector n count in report bits 4n+3:4n
// - Counts zero to eight, 1111 uncorrected
// - Largest sector count in 30h bits 7:4
// - Page maximum 1111 when correction failed
// - Worst sector index in 30h bits 2:0
// - Ties report the lowest sector number
// - Host disregards reserved bits on reads
// - Reserved bits written zero have no effect
// - ECC corrects up to eight flips per sector
// ****************************************************************
// Device end: busy flag and extended ECC status registers
// ****************************************************************
module efcs_device
	import efcs_pkg::*;
#(
	parameter int unsigned SECTORS = EFCS_SECTORS,  // Sectors per page
	parameter int unsigned CNT_W   = EFCS_CNT_W,    // Bits per count
	parameter logic [7:0]  ID_CODE = EFCS_ID_DEFAULT // Arbitrary value
)(
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	efcs_link_if.dev                      link,
	input  wire logic                     ecc_enable,
	input  wire logic                     array_done,
	input  wire logic [SECTORS*CNT_W-1:0] sector_count_in,
	output logic                          array_start,
	output logic      [7:0]               array_op,
	output logic                          busy
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [3:0]               flip_threshold;              // Programmed threshold
	logic [SECTORS*CNT_W-1:0] sector_flip_count;           // Stored report
	logic [SECTORS-1:0]       sector_over_threshold_flags; // Stored flags
	logic [3:0]               page_max_flip_count;         // Stored page maximum
	logic [2:0]               page_max_flip_sector;        // Stored worst sector
	logic                     read_pending;                // Page read in flight
	logic                     take;                        // New command seen
	logic                     allowed;                     // Opcode passes busy gate
	logic                     accept;                      // Command executed
	logic                     long_op;                     // Opcode starts array work
	logic                     page_update;                 // Status refresh strobe
	logic [SECTORS*CNT_W-1:0] next_count;                  // Cleaned input counts
	logic [SECTORS-1:0]       next_flags;                  // Flags against threshold
	logic [3:0]               next_max;                    // Largest count
	logic [2:0]               next_sector;                 // Lowest worst sector
	logic [7:0]               answer;                      // Read value of command

	// ****************************************************************
	// Command gating
	// ****************************************************************

	// A command is new while req is high and not yet acked
	assign take = link.req && !link.ack;

	// Only status and ID reads pass while busy
	assign allowed = !busy
		|| (link.op == EFCS_OP_READ_STATUS)
		|| (link.op == EFCS_OP_READ_ID);

	assign accept = take && allowed;

	// Opcodes that hand work to the array
	assign long_op = (link.op == EFCS_OP_PAGE_READ)
		|| (link.op == EFCS_OP_PROGRAM_EXEC)
		|| (link.op == EFCS_OP_BLOCK_ERASE);

	// Refresh only at the end of a page read with ECC on
	assign page_update = array_done && read_pending && ecc_enable;

	// ****************************************************************
	// Per-sector count cleaning and threshold compare
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < SECTORS; gi++) begin : g_sector
			logic [CNT_W-1:0] raw; // Count from the corrector

			assign raw = sector_count_in[gi*CNT_W +: CNT_W];

			// Anything past eight was not corrected
			assign next_count[gi*CNT_W +: CNT_W] = (raw > CNT_W'(EFCS_MAX_CORRECTED)) ?
				CNT_W'(EFCS_UNCORRECTED) : raw;

			// Equal or above the threshold raises the flag
			assign next_flags[gi] = (next_count[gi*CNT_W +: CNT_W] >=
				CNT_W'(flip_threshold));
		end
	endgenerate

	// ****************************************************************
	// Page maximum search, lowest sector wins a tie
	// ****************************************************************
	always_comb begin
		next_max    = 4'(next_count[CNT_W-1:0]);
		next_sector = 3'h0;
		for (int i = 1; i < SECTORS; i++) begin
			// Strictly greater keeps the earlier sector
			if (next_count[i*CNT_W +: CNT_W] > CNT_W'(next_max)) begin
				next_max    = 4'(next_count[i*CNT_W +: CNT_W]);
				next_sector = 3'(i);
			end
		end
	end

	// ****************************************************************
	// Link answer, one cycle after the command is seen
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link.ack     <= 1'b0;
			link.rdata   <= 8'h00;
			link.ignored <= 1'b0;
		end else begin
			link.ack     <= take;
			link.rdata   <= accept ? answer : 8'h00;
			link.ignored <= take && !allowed;
		end
	end

	// ****************************************************************
	// Read value of the current command
	// ****************************************************************
	always_comb begin
		answer = 8'h00;
		case (link.op)
			// Busy flag sits in bit 0 of the status register
			EFCS_OP_READ_STATUS: begin
				if (link.addr == EFCS_STATUS_ADDR) begin
					answer[EFCS_BUSY_BIT] = busy;
				end
			end
			// Identification byte
			EFCS_OP_READ_ID: begin
				answer = ID_CODE;
			end
			// Extended ECC registers, reserved bits zero
			EFCS_OP_READ_EXT_ECC: begin
				case (link.addr)
					EFCS_FLIP_THRESHOLD_CFG: begin
						answer = {flip_threshold, 4'h0};
					end
					EFCS_SECTOR_THRESHOLD_FLAGS: begin
						answer = {4'h0, 4'(sector_over_threshold_flags)};
					end
					EFCS_PAGE_MAX_FLIP_INFO: begin
						answer = {page_max_flip_count, 1'b0, page_max_flip_sector};
					end
					EFCS_SECTOR_FLIP_COUNT_LOW: begin
						answer = sector_flip_count[7:0];
					end
					EFCS_SECTOR_FLIP_COUNT_HIGH: begin
						answer = sector_flip_count[15:8];
					end
					default: begin
						answer = 8'h00;
					end
				endcase
			end
			default: begin
				answer = 8'h00;
			end
		endcase
	end

	// ****************************************************************
	// Busy flag
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// Power-up counts as busy
			busy <= 1'b1;
		end else if (accept && long_op) begin
			busy <= 1'b1;
		end else if (array_done) begin
			busy <= 1'b0;
		end
	end

	// ****************************************************************
	// Page read tracking, page 0 loads at power-up
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			read_pending <= 1'b1;
		end else if (accept && long_op) begin
			read_pending <= (link.op == EFCS_OP_PAGE_READ);
		end else if (array_done) begin
			read_pending <= 1'b0;
		end
	end

	// ****************************************************************
	// Array start pulse
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			array_start <= 1'b0;
			array_op    <= 8'h00;
		end else begin
			array_start <= accept && long_op;
			if (accept && long_op) begin
				array_op <= link.op;
			end
		end
	end

	// ****************************************************************
	// Threshold register, volatile
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flip_threshold <= EFCS_THRESHOLD_RESET;
		end else if (accept && (link.op == EFCS_OP_WRITE_EXT_ECC)
			&& (link.addr == EFCS_FLIP_THRESHOLD_CFG)) begin
			// Low bits are reserved and dropped
			flip_threshold <= link.wdata[EFCS_THR_LSB +: 4];
		end
	end

	// ****************************************************************
	// Page status: counts, flags and maximum in one step
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sector_flip_count           <= '0;
			sector_over_threshold_flags <= '0;
			page_max_flip_count         <= 4'h0;
			page_max_flip_sector        <= 3'h0;
		end else if (page_update) begin
			sector_flip_count           <= next_count;
			sector_over_threshold_flags <= next_flags;
			page_max_flip_count         <= next_max;
			page_max_flip_sector        <= next_sector;
		end
	end

endmodule

// ---- src/efcs_pkg.sv ----
// ****************************************************************
// Shared constants of the flip count status block
// ****************************************************************
package efcs_pkg;

	// Link field widths and sectors per page
	localparam int unsigned EFCS_BYTE_W   = 8;
	localparam int unsigned EFCS_SECTORS  = 4;
	localparam int unsigned EFCS_CNT_W    = 4;

	// Instruction codes seen on the link
	localparam logic [7:0] EFCS_OP_READ_STATUS  = 8'h0F;
	localparam logic [7:0] EFCS_OP_READ_ID      = 8'h9F;
	localparam logic [7:0] EFCS_OP_PAGE_READ    = 8'h13;
	localparam logic [7:0] EFCS_OP_PROGRAM_EXEC = 8'h10;
	localparam logic [7:0] EFCS_OP_BLOCK_ERASE  = 8'hD8;
	localparam logic [7:0] EFCS_OP_READ_EXT_ECC = 8'h7C;
	localparam logic [7:0] EFCS_OP_WRITE_EXT_ECC = 8'h7D;

	// Status register address and busy bit position
	localparam logic [7:0] EFCS_STATUS_ADDR = 8'hC0;
	localparam int unsigned EFCS_BUSY_BIT   = 0;

	// Extended ECC register addresses
	localparam logic [7:0] EFCS_FLIP_THRESHOLD_CFG     = 8'h10;
	localparam logic [7:0] EFCS_SECTOR_THRESHOLD_FLAGS = 8'h20;
	localparam logic [7:0] EFCS_PAGE_MAX_FLIP_INFO     = 8'h30;
	localparam logic [7:0] EFCS_SECTOR_FLIP_COUNT_LOW  = 8'h40;
	localparam logic [7:0] EFCS_SECTOR_FLIP_COUNT_HIGH = 8'h50;

	// Readable bit masks of the extended ECC registers
	localparam logic [7:0] EFCS_MASK_THRESHOLD = 8'hF0;
	localparam logic [7:0] EFCS_MASK_FLAGS     = 8'h0F;
	localparam logic [7:0] EFCS_MASK_MAX_INFO  = 8'hF7;
	localparam logic [7:0] EFCS_MASK_COUNT     = 8'hFF;

	// Field positions
	localparam int unsigned EFCS_THR_LSB     = 4;
	localparam int unsigned EFCS_MAX_CNT_LSB = 4;
	localparam int unsigned EFCS_MAX_SEC_W   = 3;

	// Values of the flip fields
	localparam logic [3:0] EFCS_THRESHOLD_RESET = 4'h4;
	localparam logic [3:0] EFCS_THRESHOLD_MIN   = 4'h1;
	localparam logic [3:0] EFCS_THRESHOLD_MAX   = 4'h7;
	localparam logic [3:0] EFCS_MAX_CORRECTED   = 4'h8;
	localparam logic [3:0] EFCS_UNCORRECTED     = 4'hF;

	// Controller register offsets on AHB-Lite
	localparam logic [31:0] EFCS_AHB_CMD    = 32'h0000_0000;
	localparam logic [31:0] EFCS_AHB_STATUS = 32'h0000_0004;
	localparam logic [31:0] EFCS_AHB_RDATA  = 32'h0000_0008;

	// Controller command register fields
	localparam int unsigned EFCS_CMD_OP_LSB    = 0;
	localparam int unsigned EFCS_CMD_ADDR_LSB  = 8;
	localparam int unsigned EFCS_CMD_WDATA_LSB = 16;

	// Controller status register bits
	localparam int unsigned EFCS_ST_PENDING  = 0;
	localparam int unsigned EFCS_ST_IGNORED  = 1;
	localparam int unsigned EFCS_ST_REJECTED = 2;
	localparam int unsigned EFCS_ST_DONE     = 3;

	// Arbitrary identification value, no meaning
	localparam logic [7:0] EFCS_ID_DEFAULT = 8'h5A;

endpackage

// ---- src/efcs_link_if.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Command link between controller and flash status logic
// ****************************************************************
interface efcs_link_if;
	logic       req;     // Command held until ack
	logic [7:0] op;      // Instruction code
	logic [7:0] addr;    // Register address
	logic [7:0] wdata;   // Write data
	logic       ack;     // One-cycle answer
	logic [7:0] rdata;   // Read data with ack
	logic       ignored; // Command was dropped

	// Device end
	modport dev (
		input  req,
		input  op,
		input  addr,
		input  wdata,
		output ack,
		output rdata,
		output ignored
	);

	// Controller end
	modport host (
		output req,
		output op,
		output addr,
		output wdata,
		input  ack,
		input  rdata,
		input  ignored
	);
endinterface

// ---- src/efcs_host.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Controller end: AHB-Lite registers driving the command link
// ****************************************************************
module efcs_host
	import efcs_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	efcs_link_if.host        link
);

	logic        wr_pend;   // Write data phase due
	logic [31:0] wr_addr;   // Address of that write
	logic        pending;   // Command on the link
	logic        ignored;   // Last command dropped
	logic        rejected;  // Last command refused here
	logic        done;      // Last command answered
	logic [7:0]  rdata;     // Last answer, masked
	logic [7:0]  last_op;   // Opcode of open command
	logic [7:0]  last_addr; // Address of open command
	logic        launch;    // Command write this cycle
	logic        bad_thr;   // Reserved threshold code
	logic [3:0]  thr_code;  // Threshold in the write

	// Zero wait state, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Readable bits of an extended register
	function automatic logic [7:0] ext_mask(input logic [7:0] a);
		case (a)
			EFCS_FLIP_THRESHOLD_CFG:     ext_mask = EFCS_MASK_THRESHOLD;
			EFCS_SECTOR_THRESHOLD_FLAGS: ext_mask = EFCS_MASK_FLAGS;
			EFCS_PAGE_MAX_FLIP_INFO:     ext_mask = EFCS_MASK_MAX_INFO;
			default:                     ext_mask = EFCS_MASK_COUNT;
		endcase
	endfunction

	// Command write checks
	assign launch   = wr_pend && (wr_addr == EFCS_AHB_CMD) && !pending;
	assign thr_code = hwdata[EFCS_CMD_WDATA_LSB+EFCS_THR_LSB +: 4];
	assign bad_thr  = (hwdata[EFCS_CMD_OP_LSB +: 8] == EFCS_OP_WRITE_EXT_ECC)
		&& (hwdata[EFCS_CMD_ADDR_LSB +: 8] == EFCS_FLIP_THRESHOLD_CFG)
		&& ((thr_code < EFCS_THRESHOLD_MIN) || (thr_code > EFCS_THRESHOLD_MAX));

	// ****************************************************************
	// AHB address phase capture and read data
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 32'h0000_0000;
			hrdata  <= 32'h0000_0000;
		end else if (hready) begin
			wr_pend <= hsel && htrans[1] && hwrite;
			wr_addr <= haddr;
			// Read data registered for the data phase
			if (hsel && htrans[1] && !hwrite) begin
				case (haddr)
					EFCS_AHB_STATUS: hrdata <= {28'h000_0000, done, rejected, ignored, pending};
					EFCS_AHB_RDATA:  hrdata <= {24'h00_0000, rdata};
					default:         hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ****************************************************************
	// Command launch and answer capture
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link.req   <= 1'b0;
			link.op    <= 8'h00;
			link.addr  <= 8'h00;
			link.wdata <= 8'h00;
			pending    <= 1'b0;
			ignored    <= 1'b0;
			rejected   <= 1'b0;
			done       <= 1'b0;
			rdata      <= 8'h00;
			last_op    <= 8'h00;
			last_addr  <= 8'h00;
		end else if (link.ack) begin
			// Answer closes the command
			link.req <= 1'b0;
			pending  <= 1'b0;
			done     <= 1'b1;
			ignored  <= link.ignored;
			// Reserved bits read back are dropped
			rdata    <= (last_op == EFCS_OP_READ_EXT_ECC) ?
				(link.rdata & ext_mask(last_addr)) : link.rdata;
		end else if (launch) begin
			done     <= 1'b0;
			ignored  <= 1'b0;
			rejected <= bad_thr;
			if (!bad_thr) begin
				link.req   <= 1'b1;
				pending    <= 1'b1;
				link.op    <= hwdata[EFCS_CMD_OP_LSB +: 8];
				link.addr  <= hwdata[EFCS_CMD_ADDR_LSB +: 8];
				last_op    <= hwdata[EFCS_CMD_OP_LSB +: 8];
				last_addr  <= hwdata[EFCS_CMD_ADDR_LSB +: 8];
				// Threshold write sends reserved low bits as zero
				link.wdata <= (hwdata[EFCS_CMD_OP_LSB +: 8] == EFCS_OP_WRITE_EXT_ECC) ?
					(hwdata[EFCS_CMD_WDATA_LSB +: 8] & EFCS_MASK_THRESHOLD) :
					hwdata[EFCS_CMD_WDATA_LSB +: 8];
			end
		end
	end

endmodule

// ---- verif/efcs_assertions.sv ----
`timescale 1ns/1ps
// ****
// Link and busy checks between the two ends
// ****
module efcs_assertions
	import efcs_pkg::*;
(
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       req,
	input wire logic [7:0] op,
	input wire logic [7:0] addr,
	input wire logic       ack,
	input wire logic [7:0] rdata,
	input wire logic       ignored,
	input wire logic       busy,
	input wire logic       array_start,
	input wire logic [7:0] array_op,
	input wire logic       array_done
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic taken; // New command seen at this edge
	logic ext_rd; // Extended read taken while idle
	assign taken = req && !ack;
	assign ext_rd = taken && !busy && op == EFCS_OP_READ_EXT_ECC;

	ack_latency_a: assert property (taken |=> ack) else $error("link answer late");
	ack_pulse_a: assert property (ack |=> !ack) else $error("answer held too long");
	ignore_ack_a: assert property (ignored |-> ack) else $error("drop flag without answer");
	busy_drop_a: assert property (
		taken && busy && op != EFCS_OP_READ_STATUS && op != EFCS_OP_READ_ID
		|=> ignored && rdata == 8'h00) else $error("busy device served a command");
	status_bit_a: assert property (
		taken && op == EFCS_OP_READ_STATUS && addr == EFCS_STATUS_ADDR
		|=> !ignored && rdata == {7'h00, $past(busy)}) else $error("status busy bit wrong");
	id_answer_a: assert property (
		taken && op == EFCS_OP_READ_ID |=> !ignored && rdata == EFCS_ID_DEFAULT)
		else $error("identification not served");
	start_busy_a: assert property (
		array_start |-> busy && (array_op == EFCS_OP_PAGE_READ
		|| array_op == EFCS_OP_PROGRAM_EXEC || array_op == EFCS_OP_BLOCK_ERASE))
		else $error("array work without busy");
	start_pulse_a: assert property (array_start |=> !array_start) else $error("start too long");
	done_clear_a: assert property (
		array_done && busy |=> !busy) else $error("busy not cleared at completion");
	thr_layout_a: assert property (
		ext_rd && addr == EFCS_FLIP_THRESHOLD_CFG |=> rdata[3:0] == 4'h0 && !rdata[7])
		else $error("threshold byte malformed");
	flags_resv_a: assert property (
		ext_rd && addr == EFCS_SECTOR_THRESHOLD_FLAGS |=> rdata[7:4] == 4'h0)
		else $error("flag byte reserved bits set");
	max_sector_a: assert property (
		ext_rd && addr == EFCS_PAGE_MAX_FLIP_INFO |=> !rdata[3] && rdata[2:0] <= 3'h3)
		else $error("worst sector field out of range");
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
// ****
// Both ends joined, driven over AHB-Lite
// ****
module tb;
	import efcs_pkg::*;
	logic        hclk = 1'b0;        // Bus clock
	logic        hresetn = 1'b0;     // Reset, active low
	logic        hsel = 1'b0;        // Slave select
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;       // Word transfers
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        ecc_enable = 1'b0;  // Corrector enable
	logic        array_done = 1'b0;  // Array completion
	logic [15:0] sector_count_in = 16'h0000;
	logic        array_start;
	logic [7:0]  array_op;
	logic        busy;
	int          n_fail = 0;
	int          compares = 0;
	logic [3:0]  thr = 4'h4;         // Expected threshold
	logic [7:0]  rd;                 // Last answer byte
	logic        ign;                // Last drop flag
	logic [31:0] st;                 // Last controller status word
	logic [3:0]  thr_bad [3] = '{4'h0, 4'h8, 4'hF}; // Refused threshold codes

	// Half period of 25 ns
	always #25 hclk = ~hclk;

	efcs_link_if efcs_link_if_i ();
	efcs_host efcs_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.link(efcs_link_if_i.host));
	efcs_device efcs_device_i (.hclk(hclk), .hresetn(hresetn), .link(efcs_link_if_i.dev),
		.ecc_enable(ecc_enable), .array_done(array_done), .sector_count_in(sector_count_in),
		.array_start(array_start), .array_op(array_op), .busy(busy));
	efcs_assertions efcs_assertions_i (.hclk(hclk), .hresetn(hresetn),
		.req(efcs_link_if_i.req), .op(efcs_link_if_i.op), .addr(efcs_link_if_i.addr),
		.ack(efcs_link_if_i.ack), .rdata(efcs_link_if_i.rdata),
		.ignored(efcs_link_if_i.ignored), .busy(busy), .array_start(array_start),
		.array_op(array_op), .array_done(array_done));

	// ****
	// Shared tasks
	// ****
	// Compare and count
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One single word transfer
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		// Slave answers OKAY on every transfer
		chk("hresp", 32'h0000_0000, {31'h0, hresp});
	endtask

	// Link command through the controller, answer kept
	task automatic cmd(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		int n;
		ahb(1'b1, EFCS_AHB_CMD, {8'h00, d, a, op}, q);
		n = 0;
		do begin
			ahb(1'b0, EFCS_AHB_STATUS, 32'h0000_0000, q);
			n++;
		end while (q[EFCS_ST_PENDING] !== 1'b0 && n < 20);
		st = q;
		chk("cmd_pending", 32'h0000_0000, {31'h0, q[EFCS_ST_PENDING]});
		ign = q[EFCS_ST_IGNORED];
		ahb(1'b0, EFCS_AHB_RDATA, 32'h0000_0000, q);
		rd = q[7:0];
	endtask

	// Read one extended register
	task automatic rd_ext(input logic [7:0] a);
		cmd(EFCS_OP_READ_EXT_ECC, a, 8'h00);
	endtask

	// Array completion pulse with counts
	task automatic finish_op(input logic [15:0] cnt, input logic en);
		@(posedge hclk);
		ecc_enable <= en;
		sector_count_in <= cnt;
		array_done <= 1'b1;
		@(posedge hclk);
		array_done <= 1'b0;
		@(posedge hclk);
		chk("busy_clear", 32'h0000_0000, {31'h0, busy});
	endtask

	// ****
	// Scenarios
	// ****
	// Long operation, refused traffic while busy, then completion
	task automatic run_op(input logic [7:0] op, input logic [15:0] cnt, input logic en);
		cmd(op, 8'h00, 8'h00);
		chk("op_busy", 32'h0000_0001, {31'h0, busy});
		chk("array_op", {24'h0, op}, {24'h0, array_op});
		rd_ext(EFCS_PAGE_MAX_FLIP_INFO);
		chk("busy_drop", 32'h0000_0001, {31'h0, ign});
		cmd(EFCS_OP_READ_STATUS, EFCS_STATUS_ADDR, 8'h00);
		chk("status_busy", 32'h0000_0001, {30'h0, ign, rd[EFCS_BUSY_BIT]});
		finish_op(cnt, en);
	endtask

	// Page report against counts of the last ECC read
	task automatic check_page(input logic [15:0] cnt);
		logic [3:0] c [4];
		logic [3:0] flg;
		logic [3:0] mx;
		logic [2:0] ms;
		flg = 4'h0;
		mx = 4'h0;
		ms = 3'h0;
		for (int i = 0; i < 4; i++) begin
			c[i] = cnt[4*i +: 4];
			// Above eight means uncorrected
			if (c[i] > EFCS_MAX_CORRECTED) begin
				c[i] = EFCS_UNCORRECTED;
			end
			flg[i] = (c[i] >= thr);
			// Strict compare keeps lowest sector on ties
			if (c[i] > mx) begin
				mx = c[i];
				ms = 3'(i);
			end
		end
		rd_ext(EFCS_SECTOR_THRESHOLD_FLAGS);
		chk("flags", {28'h0, flg}, {24'h0, rd});
		rd_ext(EFCS_PAGE_MAX_FLIP_INFO);
		chk("max_info", {24'h0, mx, 1'b0, ms}, {24'h0, rd});
		rd_ext(EFCS_SECTOR_FLIP_COUNT_LOW);
		chk("count_low", {24'h0, c[1], c[0]}, {24'h0, rd});
		rd_ext(EFCS_SECTOR_FLIP_COUNT_HIGH);
		chk("count_high", {24'h0, c[3], c[2]}, {24'h0, rd});
	endtask

	// Threshold write, reserved bits written zero
	task automatic set_thr(input logic [3:0] t);
		cmd(EFCS_OP_WRITE_EXT_ECC, EFCS_FLIP_THRESHOLD_CFG, {t, 4'h0});
		thr = t;
		rd_ext(EFCS_FLIP_THRESHOLD_CFG);
		chk("threshold", {24'h0, t, 4'h0}, {24'h0, rd});
	endtask

	// Verdict
	task automatic report_and_stop();
		$display("Compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (5) @(posedge hclk);
		chk("reset_busy", 32'h0000_0001, {31'h0, busy});
		hresetn <= 1'b1;
		rd_ext(EFCS_FLIP_THRESHOLD_CFG);
		chk("powerup_drop", 32'h0000_0001, {31'h0, ign});
		cmd(EFCS_OP_READ_ID, 8'h00, 8'h00);
		chk("id_busy", {24'h0, EFCS_ID_DEFAULT}, {24'h0, rd});
		finish_op(16'h0000, 1'b1);
		check_page(16'h0000);
		rd_ext(EFCS_FLIP_THRESHOLD_CFG);
		chk("thr_reset", {24'h0, EFCS_THRESHOLD_RESET, 4'h0}, {24'h0, rd});
		// Reserved codes never reach the device
		foreach (thr_bad[i]) begin
			cmd(EFCS_OP_WRITE_EXT_ECC, EFCS_FLIP_THRESHOLD_CFG, {thr_bad[i], 4'h0});
			chk("thr_rejected", 32'h0000_0001, {31'h0, st[EFCS_ST_REJECTED]});
			rd_ext(EFCS_FLIP_THRESHOLD_CFG);
			chk("thr_kept", {24'h0, thr, 4'h0}, {24'h0, rd});
		end
		set_thr(4'h3);
		run_op(EFCS_OP_PAGE_READ, 16'h8231, 1'b1);
		check_page(16'h8231);
		run_op(EFCS_OP_PAGE_READ, 16'h5A1F, 1'b1);
		check_page(16'h5A1F);
		run_op(EFCS_OP_PAGE_READ, 16'h1111, 1'b0);
		check_page(16'h5A1F);
		set_thr(4'h7);
		run_op(EFCS_OP_PAGE_READ, 16'h7689, 1'b1);
		check_page(16'h7689);
		set_thr(4'h1);
		run_op(EFCS_OP_PAGE_READ, 16'h0100, 1'b1);
		run_op(EFCS_OP_PROGRAM_EXEC, 16'h3333, 1'b0);
		run_op(EFCS_OP_BLOCK_ERASE, 16'h4444, 1'b0);
		check_page(16'h0100);
		// Mid-run reset brings back the power-up state
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk("rst_busy", 32'h0000_0001, {31'h0, busy});
		hresetn <= 1'b1;
		finish_op(16'h0000, 1'b0);
		thr = EFCS_THRESHOLD_RESET;
		rd_ext(EFCS_FLIP_THRESHOLD_CFG);
		chk("thr_rst", {24'h0, EFCS_THRESHOLD_RESET, 4'h0}, {24'h0, rd});
		check_page(16'h0000);
		report_and_stop();
	end

	// Watchdog, far beyond the expected run
	initial begin
		#(50 * 20000);
		n_fail++;
		report_and_stop();
	end
endmodule
